/* File: rtl/pfc_gate_logic.sv */
// gate decision, cycle latches and protection sequencing of the boost stage
`default_nettype none
// What this block does
// - min-off pulse overrides all and clears peak-cutoff and on latches
// - logic delay plus min-off pulse leaves 95% duty at 65kHz
// - peak-current event drops gate at once, off for rest of cycle
// - peak cutoff acts cycle by cycle from the -0.4V shunt comparator
// - peak comparator passes a 200ns deglitch before acting
// - feedback below 0.5V for 1us powers down; soft-restart when above
// - feedback above 2.7V switches the gate off immediately
// - qualified first overvoltage holds gate off until below 2.5V, no soft-start
// - backup overvoltage above 2.5V switches gate off, independent path
// - qualified second overvoltage auto-restarts with soft-start below 2.3V
// - both overvoltages: gate off until both comparators release
// - gate output is active high, one turns the transistor on
// - gate forced low while supply is under lockout level
// - each cycle starts with 600ns gate off and ramp held discharged
// - ramp crossing the averaged current ends off time, sets on latch
// - start above 12V supply with feedback above 0.5V; stop below 11V
// - soft-start ramps voltage loop, released at 95% of rated output
module pfc_gate_logic
  import pfc_gate_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              cycle_start,
  input  wire logic              ramp_cross,
  input  wire logic              peak_current_cutoff,
  input  wire logic              open_feedback_guard,
  input  wire logic              first_overvoltage_guard,
  input  wire logic              first_overvoltage_hold,
  input  wire logic              second_overvoltage_guard,
  input  wire logic              second_overvoltage_hold,
  input  wire logic              supply_on_level,
  input  wire logic              supply_lockout_level,
  input  wire logic              bulk_at_regulation,
  output logic                   gate,
  output logic                   ramp_hold,
  output logic                   soft_start,
  output logic                   peak_cutoff_active,
  output pfc_gate_pkg::run_state_e protect_state
);
  import pfc_gate_pkg::*;

  typedef struct packed {
    run_state_e       state;
    logic [OFF_W-1:0] off_cnt;
    logic             edge_prev;
    logic             on_latch;
    logic             peak_latch;
    logic             soft_start;
    logic             gate;
  } core_s;

  core_s            q;
  core_s            next_q;
  logic [IN_W-1:0]  raw_vec;
  logic [IN_W-1:0]  s;
  logic             cyc_edge;
  logic             min_off;
  logic             any_raw_fault;

  qual_if peak_qi ();
  qual_if openfb_qi ();
  qual_if ov1_qi ();
  qual_if ov2_qi ();

  assign raw_vec = {bulk_at_regulation, supply_lockout_level, supply_on_level,
                    second_overvoltage_hold, second_overvoltage_guard,
                    first_overvoltage_hold, first_overvoltage_guard,
                    open_feedback_guard, peak_current_cutoff, ramp_cross, cycle_start};

  level_sync #(.W(IN_W)) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (raw_vec),
    .q     (s)
  );

  assign peak_qi.raw   = s[B_PEAK];
  assign openfb_qi.raw = s[B_OPENFB];
  assign ov1_qi.raw    = s[B_OV1];
  assign ov2_qi.raw    = s[B_OV2];

  qual_filter #(.CYCLES(PEAK_DEGLITCH_CYC)) u_peak_filt (.clk(clk), .rst_b(rst_b), .qi(peak_qi));
  qual_filter #(.CYCLES(OPENFB_QUAL_CYC)) u_openfb_filt (.clk(clk), .rst_b(rst_b), .qi(openfb_qi));
  qual_filter #(.CYCLES(OV_QUAL_CYC))     u_ov1_filt (.clk(clk), .rst_b(rst_b), .qi(ov1_qi));
  qual_filter #(.CYCLES(OV_QUAL_CYC))     u_ov2_filt (.clk(clk), .rst_b(rst_b), .qi(ov2_qi));

  // raw overvoltage, open-feedback and lockout levels gate off before qualification; only the peak cutoff waits on its filter
  assign any_raw_fault = s[B_OV1] | s[B_OV2] | s[B_OPENFB] | s[B_LOCKOUT];

  always_comb begin
    next_q           = q;
    cyc_edge         = s[B_CYCLE] & ~q.edge_prev;
    next_q.edge_prev = s[B_CYCLE];

    // the edge cycle itself counts as the first cycle of the off pulse
    min_off = cyc_edge | (q.off_cnt != '0);
    if (cyc_edge) begin
      next_q.off_cnt = OFF_W'(MIN_OFF_CYC - 1);
    end else if (q.off_cnt != '0) begin
      next_q.off_cnt = q.off_cnt - OFF_W'(1);
    end

    // the off pulse outranks both sets, so a late ramp or peak event cannot leak over
    if (min_off) begin
      next_q.on_latch   = 1'b0;
      next_q.peak_latch = 1'b0;
    end else begin
      if (s[B_RAMP]) begin
        next_q.on_latch = 1'b1;
      end
      if (peak_qi.qual) begin
        next_q.peak_latch = 1'b1;
      end
    end

    if (s[B_REG95]) begin
      next_q.soft_start = 1'b0;
    end

    case (q.state)
      ST_OFF: begin
        if (s[B_SUP_ON] && !s[B_OPENFB]) begin
          next_q.state      = ST_RUN;
          next_q.soft_start = 1'b1;
        end
      end
      ST_RUN: begin
        if (ov1_qi.qual && ov2_qi.qual) begin
          next_q.state = ST_BOTH;
        end else if (ov2_qi.qual) begin
          next_q.state = ST_OV2;
        end else if (ov1_qi.qual) begin
          next_q.state = ST_OV1;
        end else if (openfb_qi.qual) begin
          next_q.state = ST_OPENFB;
        end
      end
      ST_OPENFB: begin
        if (!s[B_OPENFB]) begin
          next_q.state      = ST_RUN;
          next_q.soft_start = 1'b1;
        end
      end
      ST_OV1: begin
        if (ov2_qi.qual) begin
          next_q.state = ST_BOTH;
        end else if (!s[B_OV1_HOLD]) begin
          next_q.state = ST_RUN;
        end
      end
      ST_OV2: begin
        if (ov1_qi.qual) begin
          next_q.state = ST_BOTH;
        end else if (!s[B_OV2_HOLD]) begin
          next_q.state      = ST_RUN;
          next_q.soft_start = 1'b1;
        end
      end
      ST_BOTH: begin
        if (!s[B_OV1_HOLD] && !s[B_OV2_HOLD]) begin
          next_q.state = ST_RUN;
        end
      end
      default: begin
        next_q.state = ST_OFF;
      end
    endcase

    // lockout beats every other transition
    if (s[B_LOCKOUT]) begin
      next_q.state      = ST_OFF;
      next_q.soft_start = 1'b0;
    end

    // one means transistor on; registered so the pin never glitches
    next_q.gate = (next_q.state == ST_RUN) & next_q.on_latch & ~next_q.peak_latch
                  & (next_q.off_cnt == '0) & ~any_raw_fault;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= '{state: ST_OFF, off_cnt: '0, edge_prev: 1'b0, on_latch: 1'b0,
             peak_latch: 1'b0, soft_start: 1'b0, gate: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  assign gate               = q.gate;
  assign ramp_hold          = (q.off_cnt != '0) | (q.state != ST_RUN);
  assign soft_start         = q.soft_start;
  assign peak_cutoff_active = q.peak_latch;
  assign protect_state      = q.state;

  property p_minoff_clears;
    @(posedge clk) disable iff (!rst_b)
      (q.off_cnt != '0) |=> (!q.on_latch && !q.peak_latch);
  endproperty
  a_minoff_clears: assert property (p_minoff_clears)
    else $error("off pulse did not clear the latches");

  property p_duty;
    @(posedge clk) disable iff (!rst_b)
      (q.off_cnt == OFF_W'(1)) ##1 (s[B_RAMP] && q.state == ST_RUN && !any_raw_fault
        && !cyc_edge && !peak_qi.qual && !openfb_qi.qual && !ov1_qi.qual && !ov2_qi.qual)
      |=> q.gate;
  endproperty
  a_duty: assert property (p_duty)
    else $error("gate not on right after the off pulse");

  property p_peak_gate_off;
    @(posedge clk) disable iff (!rst_b)
      q.peak_latch |-> !q.gate;
  endproperty
  a_peak_gate_off: assert property (p_peak_gate_off)
    else $error("gate on while peak cutoff latched");

  property p_peak_holds;
    @(posedge clk) disable iff (!rst_b)
      (q.peak_latch && !cyc_edge && q.off_cnt == '0) |=> q.peak_latch;
  endproperty
  a_peak_holds: assert property (p_peak_holds)
    else $error("peak cutoff released inside the cycle");

  property p_peak_deglitch;
    @(posedge clk) disable iff (!rst_b)
      $rose(peak_qi.qual) |-> ($past(s[B_PEAK], 1) && $past(s[B_PEAK], 5));
  endproperty
  a_peak_deglitch: assert property (p_peak_deglitch)
    else $error("peak cutoff passed a short pulse");

  property p_openfb_down;
    @(posedge clk) disable iff (!rst_b)
      (q.state == ST_RUN && openfb_qi.qual && !ov1_qi.qual && !ov2_qi.qual && !s[B_LOCKOUT])
      |=> (q.state == ST_OPENFB);
  endproperty
  a_openfb_down: assert property (p_openfb_down)
    else $error("open feedback did not power down");

  property p_ov1_off;
    @(posedge clk) disable iff (!rst_b)
      s[B_OV1] |=> !q.gate;
  endproperty
  a_ov1_off: assert property (p_ov1_off)
    else $error("gate on after first overvoltage");

  property p_ov1_hold;
    @(posedge clk) disable iff (!rst_b)
      (q.state == ST_OV1 && s[B_OV1_HOLD]) |=> (q.state != ST_RUN);
  endproperty
  a_ov1_hold: assert property (p_ov1_hold)
    else $error("first overvoltage released early");

  property p_ov2_off;
    @(posedge clk) disable iff (!rst_b)
      s[B_OV2] |=> !q.gate;
  endproperty
  a_ov2_off: assert property (p_ov2_off)
    else $error("gate on after second overvoltage");

  property p_ov2_restart;
    @(posedge clk) disable iff (!rst_b)
      (q.state == ST_OV2 && !s[B_OV2_HOLD] && !ov1_qi.qual && !s[B_LOCKOUT])
      |=> (q.state == ST_RUN && q.soft_start);
  endproperty
  a_ov2_restart: assert property (p_ov2_restart)
    else $error("second overvoltage did not soft-restart");

  property p_both_hold;
    @(posedge clk) disable iff (!rst_b)
      (q.state == ST_BOTH && (s[B_OV1_HOLD] || s[B_OV2_HOLD]) && !s[B_LOCKOUT])
      |=> (q.state == ST_BOTH);
  endproperty
  a_both_hold: assert property (p_both_hold)
    else $error("double overvoltage released early");

  property p_lockout;
    @(posedge clk) disable iff (!rst_b)
      s[B_LOCKOUT] |=> (!q.gate && q.state == ST_OFF);
  endproperty
  a_lockout: assert property (p_lockout)
    else $error("gate on under supply lockout");

  property p_off_pulse;
    @(posedge clk) disable iff (!rst_b)
      (cyc_edge && q.state == ST_RUN) |=> (ramp_hold && !q.gate) [*8];
  endproperty
  a_off_pulse: assert property (p_off_pulse)
    else $error("off pulse too short");

  property p_gate_needs;
    @(posedge clk) disable iff (!rst_b)
      q.gate |-> (q.state == ST_RUN && q.on_latch && !q.peak_latch && q.off_cnt == '0);
  endproperty
  a_gate_needs: assert property (p_gate_needs)
    else $error("gate on without run state and on latch");

endmodule : pfc_gate_logic
`default_nettype wire

/* File: rtl/pfc_gate_pkg.sv */
// shared constants and types for the boost gate-decision logic
`default_nettype none
package pfc_gate_pkg;

  // clock and timing, figures in nanoseconds as printed
  localparam int CLK_NS           = 40;
  localparam int MIN_OFF_NS       = 600;
  localparam int PEAK_DEGLITCH_NS = 200;
  localparam int OPENFB_QUAL_NS   = 1000;
  localparam int OV_QUAL_NS       = 12000;

  // least times round up to whole cycles
  localparam int MIN_OFF_CYC      = (MIN_OFF_NS + CLK_NS - 1) / CLK_NS;
  localparam int PEAK_DEGLITCH_CYC = (PEAK_DEGLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int OPENFB_QUAL_CYC   = (OPENFB_QUAL_NS + CLK_NS - 1) / CLK_NS;
  localparam int OV_QUAL_CYC       = (OV_QUAL_NS + CLK_NS - 1) / CLK_NS;

  // off-time budget for the duty ceiling at the nominal switching rate
  localparam int SW_FREQ_HZ       = 65000;
  localparam int MAX_DUTY_PCT     = 95;
  localparam int SW_PERIOD_NS     = 1000000000 / SW_FREQ_HZ;
  localparam int OFF_BUDGET_NS    = SW_PERIOD_NS * (100 - MAX_DUTY_PCT) / 100;
  // two synchroniser stages plus the ramp sample before the gate register
  localparam int LOGIC_LAT_CYC    = 3;
  localparam bit DUTY_FITS        = ((MIN_OFF_CYC + LOGIC_LAT_CYC) * CLK_NS) <= OFF_BUDGET_NS;

  localparam int OFF_W            = $clog2(MIN_OFF_CYC + 1);

  // bit positions of the synchronised comparator vector
  localparam int IN_W             = 11;
  localparam int B_CYCLE          = 0;
  localparam int B_RAMP           = 1;
  localparam int B_PEAK           = 2;
  localparam int B_OPENFB         = 3;
  localparam int B_OV1            = 4;
  localparam int B_OV1_HOLD       = 5;
  localparam int B_OV2            = 6;
  localparam int B_OV2_HOLD       = 7;
  localparam int B_SUP_ON         = 8;
  localparam int B_LOCKOUT        = 9;
  localparam int B_REG95          = 10;

  localparam logic [IN_W-1:0] SYNC_RESET = 11'h000;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_RUN,
    ST_OPENFB,
    ST_OV1,
    ST_OV2,
    ST_BOTH
  } run_state_e;

endpackage : pfc_gate_pkg
`default_nettype wire

/* File: rtl/qual_if.sv */
// carrier between the core and a qualification filter
`default_nettype none
interface qual_if;
  logic raw;
  logic qual;
  modport filt (input raw, output qual);
  modport user (output raw, input qual);
endinterface : qual_if
`default_nettype wire

/* File: rtl/level_sync.sv */
// two-stage synchroniser for a vector of comparator levels
`default_nettype none
module level_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;

  sync_s r;
  sync_s next_r;

  always_comb begin
    next_r    = r;
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q = r.s2;
endmodule : level_sync
`default_nettype wire

/* File: rtl/qual_filter.sv */
// qualifies a level: high only after CYCLES consecutive high samples
`default_nettype none
module qual_filter #(
  parameter int CYCLES = 5
) (
  input  wire logic clk,
  input  wire logic rst_b,
  qual_if.filt      qi
);
  localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          qual;
  } filt_s;

  filt_s r;
  filt_s next_r;

  // a single low sample restarts the count, so short pulses never pass
  always_comb begin
    next_r = r;
    if (!qi.raw) begin
      next_r.cnt  = '0;
      next_r.qual = 1'b0;
    end else if (r.cnt == CW'(CYCLES - 1)) begin
      next_r.qual = 1'b1;
    end else begin
      next_r.cnt = r.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign qi.qual = r.qual;
endmodule : qual_filter
`default_nettype wire

/* File: tb/shunt_switch_model.sv */
// external boost switch with shunt: trips the peak comparator after some on time
`default_nettype none
module shunt_switch_model (
  input  wire logic       clk,
  input  wire logic [3:0] trip_width,
  input  wire logic       gate,
  output logic            peak
);
  timeunit 1ns;
  timeprecision 1ns;
  int on_cnt = 0;
  // current only builds while the gate is high; gate low resets the build-up
  always @(posedge clk) begin
    if (gate === 1'b1) begin
      on_cnt <= on_cnt + 1;
    end else begin
      on_cnt <= 0;
    end
  end
  // comparator high for trip_width cycles once the current has built up
  assign peak = (on_cnt >= 3) && (on_cnt < 3 + trip_width);
endmodule : shunt_switch_model
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the boost gate-decision logic
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import pfc_gate_pkg::*;
  logic clk = 0, rst_b = 0, cycle_start = 0, ramp_cross = 0, peak;
  logic fo_guard = 0, fo_hold = 0, so_guard = 0, so_hold = 0;
  logic fb_low = 0, sup_on = 0, lockout = 0, bulk = 0;
  logic gate, ramp_hold, soft_start, pca;
  logic [3:0] trip_width = 4'h0;
  run_state_e protect_state;
  int n_fail = 0, total_checks = 0, seed = 32'h608C2C4E, k;

  always #(CLK_NS / 2) clk = ~clk;

  pfc_gate_logic dut_u (
    .clk(clk), .rst_b(rst_b), .cycle_start(cycle_start), .ramp_cross(ramp_cross),
    .peak_current_cutoff(peak), .open_feedback_guard(fb_low),
    .first_overvoltage_guard(fo_guard), .first_overvoltage_hold(fo_hold),
    .second_overvoltage_guard(so_guard), .second_overvoltage_hold(so_hold),
    .supply_on_level(sup_on), .supply_lockout_level(lockout), .bulk_at_regulation(bulk),
    .gate(gate), .ramp_hold(ramp_hold), .soft_start(soft_start),
    .peak_cutoff_active(pca), .protect_state(protect_state));

  shunt_switch_model sw_u (.clk(clk), .trip_width(trip_width), .gate(gate), .peak(peak));

  task test_done;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick

  task wait_state(input run_state_e exp, input int bound);
    int i;
    for (i = 0; i < bound && protect_state !== exp; i++) tick(1);
    chk(32'(protect_state), 32'(exp));
  endtask : wait_state

  // one switching cycle; ramp_cross is already high during the off pulse
  task pwm_cycle(input int on_cyc);
    int i, n;
    n = 0;
    cycle_start = 1;
    ramp_cross = 1;
    for (i = 0; i < 8 && ramp_hold !== 1'b1; i++) tick(1);
    while (ramp_hold === 1'b1 && n < 40) begin
      n++;
      tick(1);
    end
    // the edge cycle already counts in the off pulse but is not yet on ramp_hold
    chk(n + 1, MIN_OFF_CYC);
    chk(32'((n + 1 + LOGIC_LAT_CYC) * CLK_NS <= OFF_BUDGET_NS), 1);
    cycle_start = 0;
    for (i = 0; i < 6 && gate !== 1'b1; i++) tick(1);
    chk(gate, 1);
    tick(on_cyc);
  endtask : pwm_cycle

  // gate may only be high when running, outside the off pulse, latch clear
  always @(negedge clk) begin
    if (gate === 1'b1) begin
      chk(ramp_hold, 0);
      chk(pca, 0);
      chk(32'(protect_state == ST_RUN), 1);
    end
  end

  initial begin
    #(CLK_NS * 30000);
    n_fail++;
    test_done;
  end

  initial begin
    tick(6);
    chk({gate, ramp_hold, soft_start, pca}, 4'b0100);
    chk(32'(protect_state), 32'(ST_OFF));
    rst_b = 1;
    chk(DUTY_FITS, 1);
    sup_on = 1;
    wait_state(ST_RUN, 8);
    chk(soft_start, 1);
    bulk = 1;
    tick(5);
    chk(soft_start, 0);
    bulk = 0;
    // random on times with comparator glitches too short to act
    for (k = 0; k < 12; k++) begin
      trip_width = 4'($unsigned($random(seed)) % 5);
      pwm_cycle(8 + ($unsigned($random(seed)) % 12));
      chk({gate, pca}, 2'b10);
    end
    trip_width = 4'h5;
    pwm_cycle(0);
    for (k = 0; k < 12 && pca !== 1'b1; k++) tick(1);
    chk(pca, 1);
    chk(gate, 0);
    tick(10);
    chk({gate, pca}, 2'b01);
    trip_width = 4'h0;
    pwm_cycle(3);
    chk(pca, 0);
    fo_guard = 1;
    fo_hold = 1;
    tick(4);
    chk(gate, 0);
    tick(OV_QUAL_CYC - 10);
    chk(32'(protect_state), 32'(ST_RUN));
    wait_state(ST_OV1, 20);
    fo_guard = 0;
    tick(6);
    chk(32'(protect_state), 32'(ST_OV1));
    fo_hold = 0;
    wait_state(ST_RUN, 8);
    chk(soft_start, 0);
    pwm_cycle(3);
    so_guard = 1;
    so_hold = 1;
    tick(4);
    chk(gate, 0);
    wait_state(ST_OV2, OV_QUAL_CYC + 10);
    so_guard = 0;
    tick(6);
    chk(32'(protect_state), 32'(ST_OV2));
    so_hold = 0;
    wait_state(ST_RUN, 8);
    chk(soft_start, 1);
    bulk = 1;
    pwm_cycle(3);
    {fo_guard, fo_hold, so_guard, so_hold} = 4'hF;
    wait_state(ST_BOTH, OV_QUAL_CYC + 10);
    {fo_guard, fo_hold, so_guard} = 3'b000;
    tick(6);
    chk(32'(protect_state), 32'(ST_BOTH));
    so_hold = 0;
    wait_state(ST_RUN, 8);
    pwm_cycle(3);
    bulk = 0;
    fb_low = 1;
    tick(4);
    chk(gate, 0);
    wait_state(ST_OPENFB, OPENFB_QUAL_CYC + 10);
    fb_low = 0;
    wait_state(ST_RUN, 8);
    chk(soft_start, 1);
    pwm_cycle(3);
    lockout = 1;
    wait_state(ST_OFF, 8);
    chk({gate, soft_start}, 2'b00);
    lockout = 0;
    // restart first, else ramp_hold from the off state stretches the measured pulse
    wait_state(ST_RUN, 8);
    pwm_cycle(3);
    rst_b = 0;
    tick(1);
    chk({gate, ramp_hold, pca}, 3'b010);
    test_done;
  end
endmodule : testbench
`default_nettype wire
